// file: verilog/stp_pkg.sv
// constants of the synthesizer test output and pll bypass block
// How it works
// - diagnostic node chosen by serial test selector
// - parallel latch low forces selector to zero
// - decode constants, ref/2, feedback, output, output/4
// - zero selects shift register serial output
// - selector 110 enters pll bypass mode
// - bypass feeds serial clock into both dividers
// - bypass post divider output drives clock out
// - bypass feedback output toggles at serial/(2n)
// - feedback output duty cycle is not symmetric
// - post divide setting one really divides two
// - falling serial transfer latches new values
package stp_pkg;
    // ------------------------------------------------------------------
    // serial frame layout
    // ------------------------------------------------------------------
    localparam int SR_W    = 12;
    localparam int T_W     = 3;
    localparam int N_W     = 2;
    localparam int M_W     = 7;
    localparam int T_MSB   = 11;
    localparam int T_LSB   = 9;
    localparam int N_MSB   = 8;
    localparam int N_LSB   = 7;
    localparam int M_MSB   = 6;
    localparam int M_LSB   = 0;
    localparam int CNT_W   = 8;
    // ------------------------------------------------------------------
    // test selector codes
    // ------------------------------------------------------------------
    localparam logic [2:0] T_SHIFT  = 3'h0;
    localparam logic [2:0] T_ONE    = 3'h1;
    localparam logic [2:0] T_REF2   = 3'h2;
    localparam logic [2:0] T_FB     = 3'h3;
    localparam logic [2:0] T_OUT    = 3'h4;
    localparam logic [2:0] T_ZERO   = 3'h5;
    localparam logic [2:0] T_BYPASS = 3'h6;
    localparam logic [2:0] T_OUT4   = 3'h7;
    // ------------------------------------------------------------------
    // post divide encodings and half-period counts
    // ------------------------------------------------------------------
    localparam logic [1:0] N_DIV2 = 2'h0;
    localparam logic [1:0] N_DIV4 = 2'h1;
    localparam logic [1:0] N_DIV8 = 2'h2;
    localparam logic [1:0] N_DIV1 = 2'h3;
    localparam logic [CNT_W-1:0] HALF_DIV2 = 8'h01;
    localparam logic [CNT_W-1:0] HALF_DIV4 = 8'h02;
    localparam logic [CNT_W-1:0] HALF_DIV8 = 8'h04;
    localparam logic [CNT_W-1:0] HALF_DIV1 = 8'h01;
    localparam logic [CNT_W-1:0] NVAL_DIV2 = 8'h02;
    localparam logic [CNT_W-1:0] NVAL_DIV4 = 8'h04;
    localparam logic [CNT_W-1:0] NVAL_DIV8 = 8'h08;
    localparam logic [CNT_W-1:0] NVAL_DIV1 = 8'h02;
    // ------------------------------------------------------------------
    // apb register map
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam int          CTRL_RUN    = 0;
    localparam logic        CTRL_RST    = 1'h1;
    localparam int          ST_T_LSB    = 0;
    localparam int          ST_N_LSB    = 4;
    localparam int          ST_M_LSB    = 8;
    localparam int          ST_BYPASS   = 16;
    localparam logic [M_W-1:0] M_RST    = 7'h00;
    localparam logic [N_W-1:0] N_RST    = 2'h0;
endpackage

// file: verilog/stp_top.sv
// synthesizer diagnostic output selector and pll bypass logic
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module stp_top (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        s_clock,
    input  wire logic        s_data,
    input  wire logic        s_load,
    input  wire logic        p_load,
    input  wire logic [6:0]  m_par,
    input  wire logic [1:0]  n_par,
    input  wire logic        vco_tick,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             synth_clock_out,
    output logic             test_out
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [12:0] sync1_q;
    logic [12:0] sync2_q;
    logic        sclk_d1_q;
    logic        sload_d1_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= 13'h0000;
            sync2_q <= 13'h0000;
        end else begin
            sync1_q <= {s_clock, s_data, s_load, p_load, m_par, n_par};
            sync2_q <= sync1_q;
        end
    end

    logic       sclk_s;
    logic       sdata_s;
    logic       sload_s;
    logic       pload_s;
    logic [6:0] m_s;
    logic [1:0] n_s;
    assign {sclk_s, sdata_s, sload_s, pload_s, m_s, n_s} = sync2_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_d1_q  <= 1'b0;
            sload_d1_q <= 1'b0;
        end else begin
            sclk_d1_q  <= sclk_s;
            sload_d1_q <= sload_s;
        end
    end

    logic sclk_rise;
    logic sload_fall;
    assign sclk_rise  = sclk_s & ~sclk_d1_q;
    assign sload_fall = ~sload_s & sload_d1_q;

    // ------------------------------------------------------------------
    // serial shift register and latched configuration
    // ------------------------------------------------------------------
    logic [stp_pkg::SR_W-1:0] shift_q;
    logic [stp_pkg::T_W-1:0]  test_sel_q;
    logic [stp_pkg::N_W-1:0]  post_sel_q;
    logic [stp_pkg::M_W-1:0]  fb_sel_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_q <= '0;
        end else if (sclk_rise && pload_s) begin
            // first bit in ends up at the top: test, post, feedback, msb first
            shift_q <= {shift_q[stp_pkg::SR_W-2:0], sdata_s};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            test_sel_q <= stp_pkg::T_SHIFT;
            post_sel_q <= stp_pkg::N_RST;
            fb_sel_q   <= stp_pkg::M_RST;
        end else if (!pload_s) begin
            // parallel latch transparent, selector held at zero
            test_sel_q <= stp_pkg::T_SHIFT;
            post_sel_q <= n_s;
            fb_sel_q   <= m_s;
        end else if (sload_fall) begin
            test_sel_q <= shift_q[stp_pkg::T_MSB:stp_pkg::T_LSB];
            post_sel_q <= shift_q[stp_pkg::N_MSB:stp_pkg::N_LSB];
            fb_sel_q   <= shift_q[stp_pkg::M_MSB:stp_pkg::M_LSB];
        end
    end

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    logic        run_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        setup;
    logic        hit;
    logic        bypass;

    assign setup  = psel & ~penable & ~pready_q;
    assign hit    = (paddr == stp_pkg::ADDR_CTRL) | (paddr == stp_pkg::ADDR_STATUS);
    assign bypass = (test_sel_q == stp_pkg::T_BYPASS);

    function automatic logic [31:0] status_word(input logic [2:0] t, input logic [1:0] n,
                                                input logic [6:0] m, input logic b);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[stp_pkg::ST_T_LSB +: 3] = t;
        w[stp_pkg::ST_N_LSB +: 2] = n;
        w[stp_pkg::ST_M_LSB +: 7] = m;
        w[stp_pkg::ST_BYPASS]     = b;
        return w;
    endfunction

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~hit;
            if (setup && !pwrite && paddr == stp_pkg::ADDR_CTRL) begin
                prdata_q <= {31'h0000_0000, run_q};
            end else if (setup && !pwrite && paddr == stp_pkg::ADDR_STATUS) begin
                prdata_q <= status_word(test_sel_q, post_sel_q, fb_sel_q, bypass);
            end else if (setup) begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            run_q <= stp_pkg::CTRL_RST;
        end else if (psel && penable && pready_q && pwrite && paddr == stp_pkg::ADDR_CTRL) begin
            run_q <= pwdata[stp_pkg::CTRL_RUN];
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------------
    // divider clock source
    // ------------------------------------------------------------------
    logic div_tick;
    // bypass swaps the vco for the serial clock on both dividers
    assign div_tick = bypass ? sclk_rise : (vco_tick & run_q);

    function automatic logic [stp_pkg::CNT_W-1:0] post_half(input logic [1:0] n);
        case (n)
            stp_pkg::N_DIV2: post_half = stp_pkg::HALF_DIV2;
            stp_pkg::N_DIV4: post_half = stp_pkg::HALF_DIV4;
            stp_pkg::N_DIV8: post_half = stp_pkg::HALF_DIV8;
            default:         post_half = stp_pkg::HALF_DIV1;
        endcase
    endfunction

    function automatic logic [stp_pkg::CNT_W-1:0] post_val(input logic [1:0] n);
        case (n)
            stp_pkg::N_DIV2: post_val = stp_pkg::NVAL_DIV2;
            stp_pkg::N_DIV4: post_val = stp_pkg::NVAL_DIV4;
            stp_pkg::N_DIV8: post_val = stp_pkg::NVAL_DIV8;
            default:         post_val = stp_pkg::NVAL_DIV1;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // post divider
    // ------------------------------------------------------------------
    logic [stp_pkg::CNT_W-1:0] post_cnt_q;
    logic                      post_out_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            post_cnt_q <= '0;
            post_out_q <= 1'b0;
        end else if (div_tick) begin
            if (post_cnt_q >= post_half(post_sel_q) - 8'h01) begin
                post_cnt_q <= '0;
                post_out_q <= ~post_out_q;
            end else begin
                post_cnt_q <= post_cnt_q + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // feedback counter: one-tick pulse per wrap, not symmetric
    // ------------------------------------------------------------------
    logic [stp_pkg::CNT_W-1:0] fb_cnt_q;
    logic                      fb_out_q;
    logic [stp_pkg::CNT_W-1:0] fb_term;
    logic [stp_pkg::CNT_W-1:0] fb_nval;

    assign fb_nval = post_val(post_sel_q);
    // bypass wraps every 2n serial clocks, otherwise every m vco ticks
    assign fb_term = bypass ? {fb_nval[stp_pkg::CNT_W-2:0], 1'b0}
                            : {1'b0, fb_sel_q};

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fb_cnt_q <= '0;
            fb_out_q <= 1'b0;
        end else if (div_tick) begin
            if (fb_cnt_q + 8'h01 >= fb_term) begin
                fb_cnt_q <= '0;
                fb_out_q <= 1'b1;
            end else begin
                fb_cnt_q <= fb_cnt_q + 8'h01;
                fb_out_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // reference divided by two and output divided by four
    // ------------------------------------------------------------------
    logic       ref2_q;
    logic [1:0] out4_q;
    logic       post_d1_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ref2_q    <= 1'b0;
            out4_q    <= 2'h0;
            post_d1_q <= 1'b0;
        end else begin
            ref2_q    <= ~ref2_q;
            post_d1_q <= post_out_q;
            if (post_out_q && !post_d1_q) begin
                out4_q <= out4_q + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // output multiplexers
    // ------------------------------------------------------------------
    logic test_d;
    logic test_q;
    logic synth_q;

    always_comb begin
        // selection from the latched selector only
        case (test_sel_q)
            stp_pkg::T_SHIFT:  test_d = shift_q[stp_pkg::SR_W-1];
            stp_pkg::T_ONE:    test_d = 1'b1;
            stp_pkg::T_REF2:   test_d = ref2_q;
            stp_pkg::T_FB:     test_d = fb_out_q;
            stp_pkg::T_OUT:    test_d = post_out_q;
            stp_pkg::T_ZERO:   test_d = 1'b0;
            stp_pkg::T_BYPASS: test_d = fb_out_q;
            default:           test_d = out4_q[1];
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            test_q  <= 1'b0;
            synth_q <= 1'b0;
        end else begin
            test_q  <= test_d;
            synth_q <= post_out_q;
        end
    end

    assign test_out        = test_q;
    assign synth_clock_out = synth_q;
endmodule

// file: tb/stp_assertions.sv
// port checker for the test output and pll bypass block
`timescale 1ns/1ps
module stp_assertions (
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic        s_clock,
    input wire logic        p_load,
    input wire logic        vco_tick,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        synth_clock_out,
    input wire logic        test_out
);
    // ----
    // helpers and properties
    // ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic [2:0] pl_q;
    logic [4:0] idle_q;
    wire        good = paddr == stp_pkg::ADDR_CTRL || paddr == stp_pkg::ADDR_STATUS;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) pl_q <= 3'h0;
        else if (p_load) pl_q <= 3'h0;
        else if (pl_q != 3'h7) pl_q <= pl_q + 3'h1;
    end
    // quiet time with no clock source moving
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) idle_q <= 5'h00;
        else if (vco_tick || s_clock || !p_load) idle_q <= 5'h00;
        else if (idle_q != 5'h1f) idle_q <= idle_q + 5'h01;
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_stat_rd;
        s_setup ##0 (!pwrite && paddr == stp_pkg::ADDR_STATUS);
    endsequence
    a_apb_answer: assert property (s_setup |=> pready && psel && penable)
        else $error("no ready in access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready stands two cycles");
    a_bad_err: assert property (s_setup ##0 !good |=> pslverr)
        else $error("unmapped access without error");
    a_bad_zero: assert property (s_setup ##0 (!good && !pwrite) |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_good_ok: assert property (s_setup ##0 good |=> !pslverr)
        else $error("mapped access flagged");
    a_preset_zero: assert property (s_stat_rd ##0 pl_q == 3'h7 |=>
        prdata[2:0] == 3'h0 && !prdata[stp_pkg::ST_BYPASS])
        else $error("selector not forced by parallel latch");
    a_clk_source: assert property (idle_q > 5'h10 |-> $stable(synth_clock_out))
        else $error("clock out moves with no source");
    a_reset_quiet: assert property ($rose(rst_b) |-> !synth_clock_out && !test_out)
        else $error("outputs active after reset");
endmodule
bind stp_top stp_assertions i_stp_assertions (.ref_clk, .rst_b, .s_clock, .p_load,
    .vco_tick, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .synth_clock_out, .test_out);

// file: tb/stp_ctl_model.sv
// board controller model driving the serial configuration pins
`timescale 1ns/1ps
module stp_ctl_model (
    input  wire logic ref_clk,
    output logic      s_clock,
    output logic      s_data,
    output logic      s_load
);
    // ----
    // serial frame tasks
    // ----
    initial begin
        s_clock = 1'b0;
        s_data = 1'b0;
        s_load = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // msb first; clock stands low between bits, data inverts once hold runs out
    task automatic shift(input logic [15:0] w, input int nb);
        for (int i = nb - 1; i >= 0; i--) begin
            s_data <= w[i];
            wait_n(4);
            s_clock <= 1'b1;
            wait_n(4);
            s_clock <= 1'b0;
            wait_n(2);
            s_data <= ~w[i];
            wait_n(2);
        end
    endtask
    task automatic load(input logic [11:0] w);
        shift({4'h0, w}, 12);
        s_load <= 1'b1;
        wait_n(4);
        s_load <= 1'b0;
        wait_n(8);
    endtask
endmodule

// file: tb/tb.sv
// self-checking bench for the test output and pll bypass block
`timescale 1ns/1ps
module tb;
    // ----
    // stimulus and checks
    // ----
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        p_load = 1'b1;
    logic        vco_tick = 1'b0;
    logic        vco_en = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        cnt_on = 1'b0;
    logic        so_q = 1'b0;
    logic        to_q = 1'b0;
    logic [6:0]  m_par = 7'h00;
    logic [1:0]  n_par = 2'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, synth_clock_out, test_out, s_clock, s_data, s_load;
    int          err_total = 0;
    int          n_compared = 0;
    int          n_tog = 0;
    int          n_rise = 0;
    stp_top i_stp_top (.ref_clk, .rst_b, .s_clock, .s_data, .s_load, .p_load, .m_par,
        .n_par, .vco_tick, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .synth_clock_out, .test_out);
    stp_ctl_model i_stp_ctl_model (.ref_clk, .s_clock, .s_data, .s_load);
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        vco_tick <= vco_en && !vco_tick;
        so_q <= synth_clock_out;
        to_q <= test_out;
        if (cnt_on && so_q != synth_clock_out) n_tog++;
        if (cnt_on && !to_q && test_out) n_rise++;
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) err_total++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        repeat (24) @(posedge ref_clk);
        apb(1'b0, stp_pkg::ADDR_CTRL, 32'h0, r, e);
        chk("ctrl", r, 32'h1);
        apb(1'b1, stp_pkg::ADDR_CTRL, 32'h0, r, e);
        apb(1'b0, stp_pkg::ADDR_CTRL, 32'h0, r, e);
        chk("run", r, 32'h0);
        apb(1'b1, stp_pkg::ADDR_CTRL, 32'h1, r, e);
        apb(1'b1, stp_pkg::ADDR_STATUS, 32'h7, r, e);
        chk("ro err", {31'h0, e}, 32'h0);
        apb(1'b0, stp_pkg::ADDR_STATUS, 32'h0, r, e);
        chk("status", r, 32'h0);
        apb(1'b0, 12'h008, 32'h0, r, e);
        chk("bad data", r, 32'h0);
        chk("bad err", {31'h0, e}, 32'h1);
    endtask
    task automatic t_codes();
        logic [31:0] r;
        logic        e;
        logic        a;
        vco_en <= 1'b1;
        for (int t = 0; t < 8; t++) begin
            i_stp_ctl_model.load({t[2:0], 2'h1, 7'h25});
            apb(1'b0, stp_pkg::ADDR_STATUS, 32'h0, r, e);
            chk("status", r, {15'h0, t == 6, 8'h25, 4'h1, 1'b0, t[2:0]});
            a = test_out;
            @(posedge ref_clk);
            if (t inside {0, 1, 5}) chk("const", {31'h0, test_out}, {31'h0, t == 1});
            if (t == 2) chk("ref half", {31'h0, test_out}, {31'h0, ~a});
            if (t == 4) chk("synth_clock_out node", {31'h0, test_out}, {31'h0, synth_clock_out});
        end
        i_stp_ctl_model.shift(16'h0005, 3);
        apb(1'b0, stp_pkg::ADDR_STATUS, 32'h0, r, e);
        chk("latched", {29'h0, r[2:0]}, 32'h7);
        vco_en <= 1'b0;
    endtask
    task automatic t_bypass();
        int nv;
        for (int i = 0; i < 2; i++) begin
            nv = i ? 4 : 2;
            i_stp_ctl_model.load({stp_pkg::T_BYPASS,
                i ? stp_pkg::N_DIV4 : stp_pkg::N_DIV1, 7'h00});
            // settle both dividers into their new period before counting
            i_stp_ctl_model.shift(16'h0000, 8);
            repeat (10) @(posedge ref_clk);
            n_tog = 0;
            n_rise = 0;
            cnt_on <= 1'b1;
            i_stp_ctl_model.shift(16'h0000, 16);
            repeat (10) @(posedge ref_clk);
            cnt_on <= 1'b0;
            @(posedge ref_clk);
            chk("out toggles", n_tog, 32 / nv);
            chk("fb pulses", n_rise, 16 / (2 * nv));
        end
    endtask
    task automatic t_preset();
        logic [31:0] r;
        logic        e;
        m_par <= 7'h31;
        n_par <= 2'h2;
        p_load <= 1'b0;
        repeat (8) @(posedge ref_clk);
        apb(1'b0, stp_pkg::ADDR_STATUS, 32'h0, r, e);
        chk("preset", r, 32'h3120);
        p_load <= 1'b1;
        repeat (8) @(posedge ref_clk);
        apb(1'b0, stp_pkg::ADDR_STATUS, 32'h0, r, e);
        chk("kept", r, 32'h3120);
    endtask
    task automatic end_of_test();
        if (err_total == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_regs();
        t_codes();
        t_bypass();
        t_preset();
        end_of_test();
    end
    initial begin
        #400000;
        err_total++;
        end_of_test();
    end
endmodule
